// File: msis_pkg.sv
package msis_pkg;

	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 8;

	// Register offsets
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
	localparam logic [7:0] ADDR_FLAGS0     = 8'h01;
	localparam logic [7:0] ADDR_FLAGS1     = 8'h02;
	localparam logic [7:0] ADDR_IRQ_EN0    = 8'h03;
	localparam logic [7:0] ADDR_IRQ_EN1    = 8'h04;
	localparam logic [7:0] ADDR_RAW_STATUS = 8'h05;

	localparam logic [15:0] SOFT_RESET_KEY = 16'h789a;
	localparam logic [15:0] REG_RESET      = 16'h0000;

	// Flag bit positions, first flag word
	localparam int unsigned BIT_CS0   = 14;
	localparam int unsigned BIT_CS1   = 12;
	localparam int unsigned BIT_CS2   = 10;
	localparam int unsigned BIT_CS3   = 8;
	localparam int unsigned BIT_UREV  = 7;
	localparam int unsigned BIT_IREV  = 6;
	localparam int unsigned BIT_SAG   = 3;
	localparam int unsigned BIT_PLOSS = 2;
	// Second flag word
	localparam int unsigned BIT_NOV   = 14;

	localparam logic [15:0] FLAGS0_MASK = 16'h55cc;
	localparam logic [15:0] ALARM_MASK  = 16'h5500;
	localparam logic [15:0] FLAGS1_MASK = 16'h4000;

	// Status conditions arriving from the measurement core
	typedef struct packed {
		logic checksum_group0_error;
		logic checksum_group1_error;
		logic checksum_group2_error;
		logic checksum_group3_error;
		logic voltage_sequence_fault;
		logic current_sequence_fault;
		logic voltage_dip_flag;
		logic phase_loss_flag;
		logic neutral_overcurrent_flag;
	} msis_cond_s;

	typedef enum logic [1:0] {
		MSIS_RUN   = 2'b00,
		MSIS_RESET = 2'b01
	} msis_rst_e;

endpackage : msis_pkg

// File: msis_top.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Functional notes
// - Full reset only on exact key write
// - Soft reset equals pin reset scope, except rdata_o and soft_reset_o
// - Soft reset register always reads zero
// - First irq from enabled first flags
// - Second irq from enabled second flags
// - Alarm pin ignores enable bits
// - Bit 14 flags group0 checksum, alarm
// - Bit 12 flags group1 checksum, alarm
// - Bit 10 flags group2 checksum, alarm
// - Bit 8 flags group3 checksum, alarm
// - Bit 7 flags voltage sequence fault
// - Bit 6 flags current sequence fault
// - Bit 3 flags voltage dip
// - Bit 2 flags phase loss
// - Enables align with flags, reset zero
// - Second word bit 14 neutral overcurrent
module msis_top
	import msis_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire msis_cond_s        cond_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   interrupt_pin_first_o,
	output logic                   interrupt_pin_second_o,
	output logic                   alarm_pin_o,
	output logic                   soft_reset_o
);

	msis_cond_s      cond_meta_reg;
	msis_cond_s      cond_sync_reg;
	msis_rst_e       rst_state_reg;
	logic            rst_n;
	logic [DATA_W-1:0] flags0_word;
	logic [DATA_W-1:0] flags1_word;
	logic            clr0;
	logic            clr1;
	logic            cs0_reg;
	logic            cs1_reg;
	logic            cs2_reg;
	logic            cs3_reg;
	logic            vseq_reg;
	logic            iseq_reg;
	logic            dip_reg;
	logic            loss_reg;
	logic            nov_reg;
	logic [DATA_W-1:0] en0_reg;
	logic [DATA_W-1:0] en1_reg;
	logic [DATA_W-1:0] raw0;
	logic [DATA_W-1:0] raw1;
	logic [DATA_W-1:0] rdata_next;
	logic            key_hit;

	function automatic logic [DATA_W-1:0] pack0(input msis_cond_s c);
		logic [DATA_W-1:0] v;
		v            = REG_RESET;
		v[BIT_CS0]   = c.checksum_group0_error;
		v[BIT_CS1]   = c.checksum_group1_error;
		v[BIT_CS2]   = c.checksum_group2_error;
		v[BIT_CS3]   = c.checksum_group3_error;
		v[BIT_UREV]  = c.voltage_sequence_fault;
		v[BIT_IREV]  = c.current_sequence_fault;
		v[BIT_SAG]   = c.voltage_dip_flag;
		v[BIT_PLOSS] = c.phase_loss_flag;
		return v;
	endfunction : pack0

	// Read strobe aimed at one register
	function automatic logic rd_hit(input logic rd, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
		return rd && (a == t);
	endfunction : rd_hit

	// Write strobe aimed at one register
	function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
		return wr && (a == t);
	endfunction : wr_hit

	// Set wins over the clearing read, so no event is lost
	function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction : sticky_next

	assign key_hit = wr_hit(wr_i, addr_i, ADDR_SOFT_RESET) && (wdata_i == SOFT_RESET_KEY);

	// Key write holds the block, except rdata_o and soft_reset_o, in reset for one cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_state_reg <= MSIS_RUN;
		end else begin
			case (rst_state_reg)
				MSIS_RUN:   rst_state_reg <= key_hit ? MSIS_RESET : MSIS_RUN;
				MSIS_RESET: rst_state_reg <= MSIS_RUN;
				default:    rst_state_reg <= MSIS_RUN;
			endcase
		end
	end

	// Soft reset only clears synchronously, same register set as the pin except rdata_o and soft_reset_o
	assign rst_n = (rst_state_reg == MSIS_RUN);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			soft_reset_o <= 1'b0;
		end else begin
			soft_reset_o <= key_hit;
		end
	end

	// Conditions come from another timing context
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cond_meta_reg <= '0;
		end else if (!rst_n) begin
			cond_meta_reg <= '0;
		end else begin
			cond_meta_reg <= cond_i;
		end
	end

	// Only the second stage is read by any logic
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cond_sync_reg <= '0;
		end else if (!rst_n) begin
			cond_sync_reg <= '0;
		end else begin
			cond_sync_reg <= cond_meta_reg;
		end
	end

	assign raw0 = pack0(cond_sync_reg);

	always_comb begin
		raw1          = REG_RESET;
		raw1[BIT_NOV] = cond_sync_reg.neutral_overcurrent_flag;
	end

	// Reading a flag word clears it in the same edge
	assign clr0 = rd_hit(rd_i, addr_i, ADDR_FLAGS0);
	assign clr1 = rd_hit(rd_i, addr_i, ADDR_FLAGS1);

	// One sticky register per condition
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs0_reg <= 1'b0;
		end else if (!rst_n) begin
			cs0_reg <= 1'b0;
		end else begin
			cs0_reg <= sticky_next(cs0_reg, raw0[BIT_CS0], clr0);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs1_reg <= 1'b0;
		end else if (!rst_n) begin
			cs1_reg <= 1'b0;
		end else begin
			cs1_reg <= sticky_next(cs1_reg, raw0[BIT_CS1], clr0);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs2_reg <= 1'b0;
		end else if (!rst_n) begin
			cs2_reg <= 1'b0;
		end else begin
			cs2_reg <= sticky_next(cs2_reg, raw0[BIT_CS2], clr0);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs3_reg <= 1'b0;
		end else if (!rst_n) begin
			cs3_reg <= 1'b0;
		end else begin
			cs3_reg <= sticky_next(cs3_reg, raw0[BIT_CS3], clr0);
		end
	end

	// Sequence flags drop on read once the sequence is correct again
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vseq_reg <= 1'b0;
		end else if (!rst_n) begin
			vseq_reg <= 1'b0;
		end else begin
			vseq_reg <= sticky_next(vseq_reg, raw0[BIT_UREV], clr0);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			iseq_reg <= 1'b0;
		end else if (!rst_n) begin
			iseq_reg <= 1'b0;
		end else begin
			iseq_reg <= sticky_next(iseq_reg, raw0[BIT_IREV], clr0);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dip_reg <= 1'b0;
		end else if (!rst_n) begin
			dip_reg <= 1'b0;
		end else begin
			dip_reg <= sticky_next(dip_reg, raw0[BIT_SAG], clr0);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			loss_reg <= 1'b0;
		end else if (!rst_n) begin
			loss_reg <= 1'b0;
		end else begin
			loss_reg <= sticky_next(loss_reg, raw0[BIT_PLOSS], clr0);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nov_reg <= 1'b0;
		end else if (!rst_n) begin
			nov_reg <= 1'b0;
		end else begin
			nov_reg <= sticky_next(nov_reg, raw1[BIT_NOV], clr1);
		end
	end

	// Reserved positions stay zero by construction
	always_comb begin
		flags0_word             = REG_RESET;
		flags0_word[BIT_CS0]    = cs0_reg;
		flags0_word[BIT_CS1]    = cs1_reg;
		flags0_word[BIT_CS2]    = cs2_reg;
		flags0_word[BIT_CS3]    = cs3_reg;
		flags0_word[BIT_UREV]   = vseq_reg;
		flags0_word[BIT_IREV]   = iseq_reg;
		flags0_word[BIT_SAG]    = dip_reg;
		flags0_word[BIT_PLOSS]  = loss_reg;
	end

	always_comb begin
		flags1_word          = REG_RESET;
		flags1_word[BIT_NOV] = nov_reg;
	end

	// Enables are masked so reserved bits can never gate a pin
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en0_reg <= REG_RESET;
		end else if (!rst_n) begin
			en0_reg <= REG_RESET;
		end else if (wr_hit(wr_i, addr_i, ADDR_IRQ_EN0)) begin
			en0_reg <= wdata_i & FLAGS0_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en1_reg <= REG_RESET;
		end else if (!rst_n) begin
			en1_reg <= REG_RESET;
		end else if (wr_hit(wr_i, addr_i, ADDR_IRQ_EN1)) begin
			en1_reg <= wdata_i & FLAGS1_MASK;
		end
	end

	always_comb begin
		case (addr_i)
			ADDR_SOFT_RESET: rdata_next = REG_RESET;
			ADDR_FLAGS0:     rdata_next = flags0_word;
			ADDR_FLAGS1:     rdata_next = flags1_word;
			ADDR_IRQ_EN0:    rdata_next = en0_reg;
			ADDR_IRQ_EN1:    rdata_next = en1_reg;
			ADDR_RAW_STATUS: rdata_next = raw0;
			default:         rdata_next = REG_RESET;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= REG_RESET;
		end else if (rd_i) begin
			rdata_o <= rdata_next;
		end else begin
			rdata_o <= REG_RESET;
		end
	end

	// Pins follow the registered flags one cycle later
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			interrupt_pin_first_o <= 1'b0;
		end else if (!rst_n) begin
			interrupt_pin_first_o <= 1'b0;
		end else begin
			interrupt_pin_first_o <= |(flags0_word & en0_reg);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			interrupt_pin_second_o <= 1'b0;
		end else if (!rst_n) begin
			interrupt_pin_second_o <= 1'b0;
		end else begin
			interrupt_pin_second_o <= |(flags1_word & en1_reg);
		end
	end

	// Alarm uses latched flags, so a brief fault is still seen
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alarm_pin_o <= 1'b0;
		end else if (!rst_n) begin
			alarm_pin_o <= 1'b0;
		end else begin
			alarm_pin_o <= |(flags0_word & ALARM_MASK);
		end
	end

endmodule : msis_top

// File: msis_top_monitor.sv
`timescale 1ns/1ps
module msis_top_monitor
	import msis_pkg::*;
(
	input wire logic		clk_i,
	input wire logic		nrst_i,
	input wire logic [7:0]	addr_i,
	input wire logic [15:0]	wdata_i,
	input wire logic		wr_i,
	input wire logic		rd_i,
	input wire msis_cond_s	cond_i,
	input wire logic [15:0]	rdata_o,
	input wire logic		interrupt_pin_first_o,
	input wire logic		interrupt_pin_second_o,
	input wire logic		alarm_pin_o,
	input wire logic		soft_reset_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	wire logic key = wr_i && addr_i == ADDR_SOFT_RESET && wdata_i == SOFT_RESET_KEY;
	property p_key; key |=> soft_reset_o; endproperty
	a_key: assert property (p_key) else $error("reset pulse missing");
	property p_only; soft_reset_o |-> $past(key); endproperty
	a_only: assert property (p_only) else $error("stray reset pulse");
	property p_clr; soft_reset_o |-> ##2 !(interrupt_pin_first_o || interrupt_pin_second_o || alarm_pin_o); endproperty
	a_clr: assert property (p_clr) else $error("pins survive reset");
	property p_srd; rd_i && addr_i == ADDR_SOFT_RESET |=> rdata_o == '0; endproperty
	a_srd: assert property (p_srd) else $error("reset word not zero");
	property p_alm; $rose(cond_i[8:5] != '0) |-> ##[1:5] alarm_pin_o; endproperty
	a_alm: assert property (p_alm) else $error("alarm missing");
	property p_idle; !rd_i |=> rdata_o == '0; endproperty
	a_idle: assert property (p_idle) else $error("read data lingers");
	property p_rs0; rd_i && addr_i == ADDR_FLAGS0 |=> (rdata_o & ~FLAGS0_MASK) == '0; endproperty
	a_rs0: assert property (p_rs0) else $error("reserved bit set");
	property p_rs1; rd_i && addr_i == ADDR_FLAGS1 |=> (rdata_o & ~FLAGS1_MASK) == '0; endproperty
	a_rs1: assert property (p_rs1) else $error("reserved bit set");
	c_srst: cover property (soft_reset_o);
	c_irq: cover property (interrupt_pin_first_o && interrupt_pin_second_o);
	c_alm: cover property ($fell(alarm_pin_o));
endmodule : msis_top_monitor
bind msis_top msis_top_monitor i_mon (.*);

// File: msis_host_model.sv
`timescale 1ns/1ps
module msis_host_model
	import msis_pkg::*;
(
	input wire logic	clk_i,
	output logic [7:0]	addr_o,
	output logic [15:0]	wdata_o,
	output logic		wr_o,
	output logic		rd_o
);
	initial {addr_o, wdata_o, wr_o, rd_o} = '0;
	// One-edge strobe; slave never stalls
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		{addr_o, wdata_o} <= {a, d};
		{wr_o, rd_o} <= {w, !w};
		@(posedge clk_i);
		{wr_o, rd_o} <= 2'b00;
	endtask : acc
endmodule : msis_host_model

// File: test_meter_status_irq_soft_reset_trigger.sv
`timescale 1ns/1ps
module test_meter_status_irq_soft_reset_trigger
	import msis_pkg::*;
;
	logic			clk_i = 1'b0;
	logic			nrst_i = 1'b0;
	logic			wr_i, rd_i, rd_d = 1'b0;
	logic [7:0]		addr_i;
	logic [15:0]	wdata_i, rdata_o;
	logic			interrupt_pin_first_o, interrupt_pin_second_o, alarm_pin_o, soft_reset_o;
	msis_cond_s		cond_i = '0;
	int				err_total = 0;
	int				checks = 0;
	int				seed = 51;
	logic [15:0]	exp_q[$];
	// Flag position per condition, index 0 lands in the second word
	logic [15:0]	pos [9] = '{16'h4000, 16'h0004, 16'h0008, 16'h0040, 16'h0080, 16'h0100, 16'h0400, 16'h1000, 16'h4000};
	initial forever #12.5 clk_i = ~clk_i;
	msis_top i_msis_top (.*);
	msis_host_model i_msis_host_model (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		i_msis_host_model.acc(1'b0, a, 16'h0000);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_msis_host_model.acc(1'b1, a, d);
	endtask : wr
	task automatic pins(input int n, input logic [2:0] e);
		repeat (n) @(posedge clk_i);
		#1;
		chk("pins", 16'({interrupt_pin_first_o, interrupt_pin_second_o, alarm_pin_o}), 16'(e));
	endtask : pins
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	always @(posedge clk_i) begin
		if (rd_d) chk("rdata", rdata_o, exp_q.pop_front());
		rd_d <= rd_i;
	end
	initial begin
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(ADDR_IRQ_EN0, 16'h0000);
		rd(ADDR_IRQ_EN1, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			cond_i <= msis_cond_s'(9'h001 << i);
			pins(6, {2'b00, i > 4});
			rd(ADDR_RAW_STATUS, i > 0 ? pos[i] : 16'h0000);
			rd(ADDR_FLAGS0, i > 0 ? pos[i] : 16'h0000);
			rd(ADDR_FLAGS1, i > 0 ? 16'h0000 : pos[i]);
			cond_i <= '0;
			repeat (5) @(posedge clk_i);
			rd(ADDR_FLAGS0, i > 0 ? pos[i] : 16'h0000);
			rd(ADDR_FLAGS1, i > 0 ? 16'h0000 : pos[i]);
		end
		$display("flag scan finished");
		cond_i <= '1;
		pins(6, 3'b001);
		wr(ADDR_IRQ_EN0, 16'hffff);
		wr(ADDR_IRQ_EN1, 16'hffff);
		pins(3, 3'b111);
		rd(ADDR_IRQ_EN0, FLAGS0_MASK);
		wr(ADDR_IRQ_EN0, 16'h0000);
		pins(3, 3'b011);
		wr(ADDR_IRQ_EN0, 16'h0004);
		cond_i <= '0;
		pins(5, 3'b111);
		rd(ADDR_FLAGS0, FLAGS0_MASK);
		pins(3, 3'b010);
		rd(ADDR_FLAGS1, FLAGS1_MASK);
		pins(3, 3'b000);
		$display("interrupt checks finished");
		repeat (3) wr(ADDR_SOFT_RESET, 16'($random(seed)) | 16'h8000);
		rd(ADDR_IRQ_EN0, 16'h0004);
		rd(ADDR_SOFT_RESET, 16'h0000);
		wr(ADDR_SOFT_RESET, SOFT_RESET_KEY);
		repeat (2) @(posedge clk_i);
		rd(ADDR_IRQ_EN0, 16'h0000);
		rd(8'h10, 16'h0000);
		repeat (2) @(posedge clk_i);
		$display("soft reset checks finished");
		print_verdict();
	end
endmodule : test_meter_status_irq_soft_reset_trigger
